//--- design/wmisa_pkg.sv
// Package with register map, field layout and event carrier of the interrupt status aggregator.
package wmisa_pkg;
  localparam logic [7:0]  WMISA_OFS_PRI_STATUS = 8'h80;
  localparam logic [7:0]  WMISA_OFS_SEC0       = 8'h84;
  localparam logic [7:0]  WMISA_OFS_SEC1       = 8'h88;
  localparam logic [7:0]  WMISA_OFS_SEC2       = 8'h8C;
  localparam logic [7:0]  WMISA_OFS_SEC3       = 8'h90;
  localparam logic [7:0]  WMISA_OFS_SEC4       = 8'h94;
  localparam logic [7:0]  WMISA_OFS_PRI_ENABLE = 8'hA0;
  localparam logic [31:0] WMISA_RESET_VALUE    = 32'h0000_0000;
  localparam logic [31:0] WMISA_SEC0_MASK      = 32'h03FF_03FF;
  localparam logic [31:0] WMISA_SEC1_MASK      = 32'h03FF_03FF;
  localparam logic [31:0] WMISA_SEC2_MASK      = 32'h7F07_03FF;
  localparam logic [31:0] WMISA_SEC3_MASK      = 32'h03FF_03FF;
  localparam logic [31:0] WMISA_SEC4_MASK      = 32'h0000_03FF;
  localparam logic [31:0] WMISA_PRI_DIRECT     = 32'h0137_F23F;
  localparam logic [31:0] WMISA_PRI_ENA_MASK   = 32'h0FBF_FFFF;
  localparam int          WMISA_QUEUES         = 10;

  typedef struct packed {
    logic       rx_good;
    logic       rx_desc_request;
    logic       rx_error;
    logic       rx_idle_timeout;
    logic       rx_list_empty;
    logic       rx_fifo_overrun;
    logic       tx_idle_timeout;
    logic       stats_threshold;
    logic       software_event;
    logic       phy_rx_error;
    logic       key_lookup_miss;
    logic       beacon_alert;
    logic       beacon_weak_signal;
    logic       beacon_missing;
    logic       beacon_queue_empty;
    logic       chirp_seen;
    logic       pin_event;
    logic       bus_master_abort;
    logic       address_parity;
    logic       data_parity;
    logic [6:0] beacon_events;
  } wmisa_direct_s;

  typedef struct packed {
    logic [9:0] tx_good;
    logic [9:0] tx_desc_request;
    logic [9:0] tx_error;
    logic [9:0] tx_list_empty;
    logic [9:0] tx_underrun;
    logic [9:0] rate_overflow;
    logic [9:0] rate_underrun;
    logic [9:0] queue_trigger;
  } wmisa_queue_s;
endpackage : wmisa_pkg

//--- design/wmisa_top.sv
// Interrupt status aggregator: primary and secondary status, primary enable and host interrupt.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Bits 6,7 summarise secondary 0 fields.
// - Bit 8 ORs per-queue transmit errors.
// - Bit 10 ORs per-queue list-empty bits.
// - Bit 11 ORs per-queue underrun bits.
// - Bit 19 ORs three host-bus error bits.
// - Bit 23 ORs secondary 2 beacon event bits 24-29; bit 30 is not included.
// - Bit 25 ORs per-queue rate overflow bits.
// - Bit 26 ORs per-queue rate underrun bits.
// - Bit 27 ORs per-queue trigger bits.
// - Bits 0-5 flag receive events.
// - Bit 9 is one shared transmit idle timeout.
// - Bits 12-18 flag statistics, software, PHY, key lookup miss, beacon events.
// - Bit 20 flags empty beacon queue alert.
// - Bit 24 pin event, bit 21 chirp.
// - Reserved primary bits written zero, read zero.
// - Secondary registers reset zero, write-one clears.
// - Secondary 0 holds good and desc-request fields.
// - Secondary 1 holds error and list-empty fields.
// - Secondary 2 holds underrun and bus errors.
// - Secondary 2 bits 24-30 flag beacon events.
// - Secondary 3 rate fields, secondary 4 triggers.
// - Enable bits 0,1 gate receive interrupts.
// - Primary status at 0x80, write-one clears directly latched bits.
module wmisa_top (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    warm_reset_n,
  input  wire wmisa_pkg::wmisa_direct_s direct_events,
  input  wire wmisa_pkg::wmisa_queue_s  queue_events,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic [31:0]                  reg_rdata,
  output logic                         host_irq
);
  import wmisa_pkg::*;

  logic [31:0] sec_reg [5];
  logic [31:0] sec_next [5];
  logic [31:0] sec_set [5];
  logic [31:0] sec_mask [5];
  logic [31:0] pri_direct_reg;
  logic [31:0] pri_enable_reg;
  logic [31:0] reg_rdata_reg;
  logic        host_irq_reg;
  logic        warm_q1_reg;
  logic        warm_q2_reg;

  wire logic        wr_pri = reg_write && (reg_addr == WMISA_OFS_PRI_STATUS);
  wire logic        wr_ena = reg_write && (reg_addr == WMISA_OFS_PRI_ENABLE);
  wire logic [31:0] sec_clear [5];
  wire logic [31:0] pri_set;
  wire logic [31:0] pri_direct_next;
  wire logic [31:0] pri_status;
  wire logic [31:0] rdata_next;
  wire logic        irq_next;
  wire logic        warm_active = !warm_q2_reg;

  // Secondary event sources placed at their field positions.
  assign sec_set[0] = {6'h0, queue_events.tx_desc_request, 6'h0, queue_events.tx_good};
  assign sec_set[1] = {6'h0, queue_events.tx_list_empty, 6'h0, queue_events.tx_error};
  assign sec_set[2] = {1'b0, direct_events.beacon_events, 5'h0, direct_events.data_parity,
                       direct_events.address_parity, direct_events.bus_master_abort,
                       6'h0, queue_events.tx_underrun};
  assign sec_set[3] = {6'h0, queue_events.rate_underrun, 6'h0, queue_events.rate_overflow};
  assign sec_set[4] = {22'h0, queue_events.queue_trigger};
  assign sec_mask[0] = WMISA_SEC0_MASK;
  assign sec_mask[1] = WMISA_SEC1_MASK;
  assign sec_mask[2] = WMISA_SEC2_MASK;
  assign sec_mask[3] = WMISA_SEC3_MASK;
  assign sec_mask[4] = WMISA_SEC4_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sec
      wire logic [7:0] ofs = WMISA_OFS_SEC0 + 8'(4 * gi);
      assign sec_clear[gi] = (reg_write && (reg_addr == ofs)) ? reg_wdata : 32'h0;
      // Set wins over a clear in the same cycle.
      assign sec_next[gi] = ((sec_reg[gi] & ~sec_clear[gi]) | sec_set[gi]) & sec_mask[gi];
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sec_reg[gi] <= WMISA_RESET_VALUE;
        end else if (warm_active) begin
          sec_reg[gi] <= WMISA_RESET_VALUE;
        end else begin
          sec_reg[gi] <= sec_next[gi];
        end
      end
    end
  endgenerate

  // Directly latched primary events.
  assign pri_set = {4'h0, 3'h0, direct_events.pin_event, 2'h0, direct_events.chirp_seen,
                    direct_events.beacon_queue_empty, 1'b0,
                    direct_events.beacon_missing, direct_events.beacon_weak_signal,
                    direct_events.beacon_alert, direct_events.key_lookup_miss,
                    direct_events.phy_rx_error, direct_events.software_event,
                    direct_events.stats_threshold, 2'h0, direct_events.tx_idle_timeout, 3'h0,
                    direct_events.rx_fifo_overrun, direct_events.rx_list_empty,
                    direct_events.rx_idle_timeout, direct_events.rx_error,
                    direct_events.rx_desc_request, direct_events.rx_good};
  assign pri_direct_next = ((pri_direct_reg & ~(wr_pri ? reg_wdata : 32'h0)) | pri_set)
                           & WMISA_PRI_DIRECT;

  // Summary bits follow the secondary registers; reserved bits stay zero.
  wire logic tx_good_summary         = |sec_reg[0][WMISA_QUEUES-1:0];
  wire logic tx_desc_request_summary = |sec_reg[0][16 +: WMISA_QUEUES];
  wire logic tx_error_summary        = |sec_reg[1][WMISA_QUEUES-1:0];
  wire logic tx_list_empty_summary   = |sec_reg[1][16 +: WMISA_QUEUES];
  wire logic tx_underrun_summary     = |sec_reg[2][WMISA_QUEUES-1:0];
  wire logic host_bus_error_summary  = |sec_reg[2][18:16];
  wire logic beacon_misc_summary     = |sec_reg[2][29:24];
  wire logic rate_overflow_summary   = |sec_reg[3][WMISA_QUEUES-1:0];
  wire logic rate_underrun_summary   = |sec_reg[3][16 +: WMISA_QUEUES];
  wire logic queue_trigger_summary   = |sec_reg[4][WMISA_QUEUES-1:0];

  assign pri_status = pri_direct_reg
                    | {4'h0, queue_trigger_summary, rate_underrun_summary, rate_overflow_summary,
                       1'b0, beacon_misc_summary, 3'h0, host_bus_error_summary, 7'h0,
                       tx_underrun_summary, tx_list_empty_summary, 1'b0, tx_error_summary,
                       tx_desc_request_summary, tx_good_summary, 6'h0};

  assign rdata_next = !reg_read ? 32'h0 :
                      (reg_addr == WMISA_OFS_PRI_STATUS) ? pri_status :
                      (reg_addr == WMISA_OFS_SEC0)       ? sec_reg[0] :
                      (reg_addr == WMISA_OFS_SEC1)       ? sec_reg[1] :
                      (reg_addr == WMISA_OFS_SEC2)       ? sec_reg[2] :
                      (reg_addr == WMISA_OFS_SEC3)       ? sec_reg[3] :
                      (reg_addr == WMISA_OFS_SEC4)       ? sec_reg[4] :
                      (reg_addr == WMISA_OFS_PRI_ENABLE) ? pri_enable_reg : 32'h0;

  assign irq_next = |(pri_status & pri_enable_reg);

  // Warm reset is synchronised before use.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      warm_q1_reg <= 1'b0;
      warm_q2_reg <= 1'b0;
    end else begin
      warm_q1_reg <= warm_reset_n;
      warm_q2_reg <= warm_q1_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pri_direct_reg <= WMISA_RESET_VALUE;
      pri_enable_reg <= WMISA_RESET_VALUE;
    end else if (warm_active) begin
      pri_direct_reg <= WMISA_RESET_VALUE;
      pri_enable_reg <= WMISA_RESET_VALUE;
    end else begin
      pri_direct_reg <= pri_direct_next;
      if (wr_ena) begin
        pri_enable_reg <= reg_wdata & WMISA_PRI_ENA_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_reg <= WMISA_RESET_VALUE;
      host_irq_reg  <= 1'b0;
    end else begin
      reg_rdata_reg <= rdata_next;
      host_irq_reg  <= irq_next;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign host_irq  = host_irq_reg;

  AST_TXOK_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[6] == (|sec_reg[0][9:0]))
    else $error("tx good summary wrong");
  AST_TXDESC_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[7] == (|sec_reg[0][25:16]))
    else $error("tx desc request summary wrong");
  AST_TXERR_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[8] == (|sec_reg[1][9:0]))
    else $error("tx error summary wrong");
  AST_EOL_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[10] == (|sec_reg[1][25:16]))
    else $error("list empty summary wrong");
  AST_URN_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[11] == (|sec_reg[2][9:0]))
    else $error("underrun summary wrong");
  AST_HOST_BUS_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[19] == (|sec_reg[2][18:16]))
    else $error("host bus error summary wrong");
  AST_BCN_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[23] == (|sec_reg[2][29:24]))
    else $error("beacon summary wrong");
  AST_RATE_OVF_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[25] == (|sec_reg[3][9:0]))
    else $error("rate overflow summary wrong");
  AST_RATE_URN_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[26] == (|sec_reg[3][25:16]))
    else $error("rate underrun summary wrong");
  AST_TRIG_SUMMARY: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[27] == (|sec_reg[4][9:0]))
    else $error("trigger summary wrong");

  AST_RX_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.rx_good && warm_q2_reg |=> pri_status[0])
    else $error("rx good lost");
  AST_RX_OVERRUN_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.rx_fifo_overrun && warm_q2_reg |=> pri_status[5])
    else $error("rx overrun lost");
  AST_TX_IDLE_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.tx_idle_timeout && warm_q2_reg |=> pri_status[9])
    else $error("tx idle timeout lost");
  AST_STATS_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.stats_threshold && warm_q2_reg |=> pri_status[12])
    else $error("stats threshold lost");
  AST_BMISS_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.beacon_missing && warm_q2_reg |=> pri_status[18])
    else $error("beacon missing lost");
  AST_BNR_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.beacon_queue_empty && warm_q2_reg |=> pri_status[20])
    else $error("beacon queue empty lost");
  AST_PIN_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.pin_event && warm_q2_reg |=> pri_status[24])
    else $error("pin event lost");
  AST_CHIRP_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.chirp_seen && warm_q2_reg |=> pri_status[21])
    else $error("chirp lost");
  AST_RES_ZERO: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_status[31:28] == 4'h0 && !pri_status[22])
    else $error("reserved bits set");

  AST_SEC_SET: assert property (
    @(posedge clk) disable iff (!reset_n || !warm_q2_reg)
    queue_events.tx_good[0] && warm_q2_reg |=> sec_reg[0][0])
    else $error("event lost");
  AST_SEC_CLEAR: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_write && (reg_addr == WMISA_OFS_SEC0) && reg_wdata[0] && !queue_events.tx_good[0] |=> !sec_reg[0][0])
    else $error("secondary clear ignored");
  AST_SEC_WARM: assert property (
    @(posedge clk) disable iff (!reset_n)
    !warm_q2_reg |=> (sec_reg[0] | sec_reg[1] | sec_reg[2] | sec_reg[3] | sec_reg[4]) == 32'h0)
    else $error("secondary kept over warm reset");
  AST_SEC0_FIELDS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sec_reg[0] & 32'hFC00_FC00) == 32'h0)
    else $error("secondary 0 reserved bit set");
  AST_SEC1_FIELDS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sec_reg[1] & 32'hFC00_FC00) == 32'h0)
    else $error("secondary 1 reserved bit set");
  AST_SEC2_FIELDS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sec_reg[2] & 32'h80F8_FC00) == 32'h0)
    else $error("secondary 2 reserved bit set");
  AST_BUS_ERR_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.data_parity && warm_q2_reg |=> sec_reg[2][18])
    else $error("data parity lost");
  AST_DRIFT_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    direct_events.beacon_events[6] && warm_q2_reg |=> sec_reg[2][30])
    else $error("timestamp drift lost");
  AST_SEC3_FIELDS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sec_reg[3] & 32'hFC00_FC00) == 32'h0)
    else $error("secondary 3 reserved bit set");
  AST_SEC4_FIELDS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sec_reg[4] & 32'hFFFF_FC00) == 32'h0)
    else $error("secondary 4 reserved bit set");

  AST_ENA_RESERVED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pri_enable_reg & 32'hF040_0000) == 32'h0)
    else $error("enable reserved bit set");
  AST_ENA_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_ena && warm_q2_reg |=> pri_enable_reg[1:0] == $past(reg_wdata[1:0]))
    else $error("receive enable bits not written");
  AST_ENA_GATE: assert property (
    @(posedge clk) disable iff (!reset_n)
    pri_enable_reg == 32'h0 |=> !host_irq)
    else $error("irq without enable");
  AST_PRI_CLEAR: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_pri && reg_wdata[0] && !direct_events.rx_good |=> !pri_status[0])
    else $error("primary clear ignored");
  AST_PRI_WARM: assert property (
    @(posedge clk) disable iff (!reset_n)
    !warm_q2_reg |=> pri_direct_reg == 32'h0 && pri_enable_reg == 32'h0)
    else $error("primary kept over warm reset");
  AST_READ_DATA: assert property (
    @(posedge clk) disable iff (!reset_n)
    !reg_read |=> reg_rdata == 32'h0)
    else $error("read data without read");
  AST_READ_STATUS: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_read && (reg_addr == WMISA_OFS_PRI_STATUS) |=> reg_rdata == $past(pri_status))
    else $error("primary status read wrong");
  AST_READ_ENABLE: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_read && (reg_addr == WMISA_OFS_PRI_ENABLE) |=> reg_rdata == $past(pri_enable_reg))
    else $error("enable read wrong");
  AST_READ_SEC2: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_read && (reg_addr == WMISA_OFS_SEC2) |=> reg_rdata == $past(sec_reg[2]))
    else $error("secondary 2 read wrong");
  AST_IRQ: assert property (
    @(posedge clk) disable iff (!reset_n)
    |(pri_status & pri_enable_reg) |=> host_irq)
    else $error("irq not raised");
  AST_IRQ_LOW: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(|(pri_status & pri_enable_reg)) |=> !host_irq)
    else $error("irq stuck");

  COV_IRQ: cover property (@(posedge clk) disable iff (!reset_n) $rose(host_irq));
  COV_CLEAR: cover property (@(posedge clk) disable iff (!reset_n) wr_pri && |pri_direct_reg);
  COV_SEC_CLEAR: cover property (@(posedge clk) disable iff (!reset_n) $fell(pri_status[6]));
  COV_WARM: cover property (@(posedge clk) disable iff (!reset_n) $fell(warm_q2_reg));
  COV_SET_WINS: cover property (@(posedge clk) disable iff (!reset_n) wr_pri && reg_wdata[0] && direct_events.rx_good);
endmodule : wmisa_top
`default_nettype wire

//--- dv/wmisa_test.sv
// Self-checking testbench of the interrupt status aggregator.
`timescale 1ns/100ps
`default_nettype none
module wmisa_test;
  import wmisa_pkg::*;
  logic          clk, reset_n, warm_reset_n, reg_write, reg_read, host_irq;
  wmisa_direct_s direct_events, d;
  wmisa_queue_s  queue_events;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, seed, pd, ena, v;
  logic [95:0]   qr;
  logic [31:0]   sreg [5];
  int            mismatches, n_checks;
  logic [7:0]    offs [7] = '{WMISA_OFS_PRI_STATUS, WMISA_OFS_SEC0, WMISA_OFS_SEC1, WMISA_OFS_SEC2,
                              WMISA_OFS_SEC3, WMISA_OFS_SEC4, WMISA_OFS_PRI_ENABLE};

  wmisa_top i_wmisa_top (.clk(clk), .reset_n(reset_n), .warm_reset_n(warm_reset_n),
    .direct_events(direct_events), .queue_events(queue_events), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .host_irq(host_irq));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] pri();
    logic [31:0] s;
    s = pd;
    s[6] = |sreg[0][9:0];
    s[7] = |sreg[0][25:16];
    s[8] = |sreg[1][9:0];
    s[10] = |sreg[1][25:16];
    s[11] = |sreg[2][9:0];
    s[19] = |sreg[2][18:16];
    s[23] = |sreg[2][29:24];
    s[25] = |sreg[3][9:0];
    s[26] = |sreg[3][25:16];
    s[27] = |sreg[4][9:0];
    return s;
  endfunction

  function automatic logic [31:0] expect_rd(input logic [7:0] a);
    if (a == WMISA_OFS_PRI_STATUS) return pri();
    if (a == WMISA_OFS_PRI_ENABLE) return ena;
    if (a >= 8'h84 && a <= 8'h94) return sreg[3'((a - 8'h84) >> 2)];
    return 32'h0000_0000;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    if (a == WMISA_OFS_PRI_STATUS || a == WMISA_OFS_PRI_ENABLE) dat &= WMISA_PRI_ENA_MASK;
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge clk);
    reg_write <= 1'h0;
    if (a == WMISA_OFS_PRI_STATUS) pd &= ~dat;
    else if (a == WMISA_OFS_PRI_ENABLE) ena = dat & WMISA_PRI_ENA_MASK;
    else if (a >= 8'h84 && a <= 8'h94) sreg[3'((a - 8'h84) >> 2)] &= ~dat;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'h0;
    #1 dat = reg_rdata;
  endtask

  task automatic ev(input wmisa_direct_s e, input wmisa_queue_s q);
    @(posedge clk);
    direct_events <= e;
    queue_events <= q;
    @(posedge clk);
    direct_events <= '0;
    queue_events <= '0;
    pd |= {7'h00, e.pin_event, 2'h0, e.chirp_seen, e.beacon_queue_empty, 1'h0, e.beacon_missing,
           e.beacon_weak_signal, e.beacon_alert, e.key_lookup_miss, e.phy_rx_error, e.software_event,
           e.stats_threshold, 2'h0, e.tx_idle_timeout, 3'h0, e.rx_fifo_overrun, e.rx_list_empty,
           e.rx_idle_timeout, e.rx_error, e.rx_desc_request, e.rx_good};
    sreg[0] |= {6'h00, q.tx_desc_request, 6'h00, q.tx_good};
    sreg[1] |= {6'h00, q.tx_list_empty, 6'h00, q.tx_error};
    sreg[2] |= {1'h0, e.beacon_events, 5'h00, e.data_parity, e.address_parity, e.bus_master_abort,
                6'h00, q.tx_underrun};
    sreg[3] |= {6'h00, q.rate_underrun, 6'h00, q.rate_overflow};
    sreg[4] |= {22'h000000, q.queue_trigger};
  endtask

  task automatic check_all();
    foreach (offs[k]) begin
      rd(offs[k], v);
      chk($sformatf("reg %h", offs[k]), v, expect_rd(offs[k]));
    end
    rd(8'h98, v);
    chk("unmapped", v, 32'h0000_0000);
    chk("host_irq", {31'h0, host_irq}, {31'h0, |(pri() & ena)});
  endtask

  task automatic end_sim();
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    seed = 32'h0000_0015;
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata, pd, ena} = '0;
    {direct_events, queue_events} = '0;
    warm_reset_n = 1'h1;
    foreach (sreg[k]) sreg[k] = 32'h0000_0000;
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge clk);
    check_all();
    wr(WMISA_OFS_PRI_ENABLE, 32'hFFFF_FFFF);
    wr(8'h98, 32'hFFFF_FFFF);
    d = '0;
    d.beacon_events = 7'h40;
    ev(d, '0);
    rd(WMISA_OFS_SEC2, v);
    chk("timestamp drift", v, 32'h4000_0000);
    check_all();
    wr(WMISA_OFS_SEC2, 32'h4000_0000);
    for (int i = 0; i < 80; i++) begin
      d = wmisa_direct_s'(27'(rnd() & rnd()));
      qr = {rnd() & rnd(), rnd() & rnd(), rnd() & rnd()};
      ev(d, wmisa_queue_s'(qr[79:0]));
      if (i % 3 == 2) wr(offs[rnd() % 32'd7], rnd() | rnd());
      if (i % 5 == 4) check_all();
    end
    d = '0;
    d.rx_good = 1'h1;
    @(posedge clk);
    direct_events <= d;
    reg_write <= 1'h1;
    reg_addr <= WMISA_OFS_PRI_STATUS;
    reg_wdata <= 32'h0000_0001;
    @(posedge clk);
    direct_events <= '0;
    reg_write <= 1'h0;
    pd[0] = 1'h1;
    check_all();
    warm_reset_n <= 1'h0;
    repeat (4) @(posedge clk);
    warm_reset_n <= 1'h1;
    repeat (3) @(posedge clk);
    {pd, ena} = '0;
    foreach (sreg[k]) sreg[k] = 32'h0000_0000;
    check_all();
    end_sim();
  end
endmodule // wmisa_test
`default_nettype wire
